// ### rtl/pod_pkg.sv
package pod_pkg;

    // ------------------------------------------------------------
    // Divide-select codes
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_DIV2  = 3'h0;
    localparam logic [2:0] SEL_DIV16 = 3'h1;
    localparam logic [2:0] SEL_DIV4  = 3'h2;
    localparam logic [2:0] SEL_DIV5  = 3'h3;
    localparam logic [2:0] SEL_DIV6  = 3'h4;
    localparam logic [2:0] SEL_DIV8  = 3'h5;
    localparam logic [2:0] SEL_DIV9  = 3'h6;
    localparam logic [2:0] SEL_DIV10 = 3'h7;

    // ------------------------------------------------------------
    // Division factors and high times in input clock cycles
    // ------------------------------------------------------------
    localparam int         FACT_W     = 5;
    localparam logic [4:0] FACT_2     = 5'h02;
    localparam logic [4:0] FACT_4     = 5'h04;
    localparam logic [4:0] FACT_5     = 5'h05;
    localparam logic [4:0] FACT_6     = 5'h06;
    localparam logic [4:0] FACT_8     = 5'h08;
    localparam logic [4:0] FACT_9     = 5'h09;
    localparam logic [4:0] FACT_10    = 5'h0A;
    localparam logic [4:0] FACT_16    = 5'h10;
    localparam logic [4:0] HIGH_5     = 5'h02;   // 40 percent of 5
    localparam logic [4:0] HIGH_9     = 5'h04;   // 44 percent of 9

    // ------------------------------------------------------------
    // Frequency relations
    // ------------------------------------------------------------
    localparam int         VCO_MULT    = 15;     // VCO rate over oscillator rate
    localparam int         CPU_MAX_MHZ = 40;     // Highest allowed output rate
    localparam int         VCO_MHZ_DEF = 160;    // Default VCO rate in use

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RST_SEL     = SEL_DIV2;

endpackage : pod_pkg

// ### rtl/pod_divider.sv
`timescale 1ns/100ps

module pod_divider
    import pod_pkg::*;
#(
    parameter int VCO_MHZ = VCO_MHZ_DEF
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    // Divide selection from software logic
    input  wire logic [2:0]        div_sel,
    // Divided clock and status
    output logic                   pll_clk,
    output logic [FACT_W-1:0]      div_factor,
    output logic [7:0]             ratio_num,
    output logic                   odd_factor,
    output logic                   over_limit
);

    // ------------------------------------------------------------
    // Derived constants
    // ------------------------------------------------------------
    localparam logic [FACT_W-1:0] CNT_ZERO = 5'h00;           // First cycle of a period
    localparam logic [FACT_W-1:0] CNT_STEP = 5'h01;           // One input cycle
    localparam logic [FACT_W-1:0] RST_HIGH = FACT_2 >> 1;     // High time of reset factor
    localparam logic [7:0]        RATIO    = 8'(VCO_MULT);    // Output rate numerator

    // ------------------------------------------------------------
    // Decode of the selection field
    // ------------------------------------------------------------
    logic [FACT_W-1:0] dec_fact;
    logic [FACT_W-1:0] dec_high;
    logic              dec_odd;
    logic              dec_fast;

    // Factor and high time per code
    always_comb begin
        unique case (div_sel)
            SEL_DIV2: begin
                dec_fact = FACT_2;
                dec_high = FACT_2 >> 1;
            end
            SEL_DIV16: begin
                dec_fact = FACT_16;
                dec_high = FACT_16 >> 1;
            end
            SEL_DIV4: begin
                dec_fact = FACT_4;
                dec_high = FACT_4 >> 1;
            end
            SEL_DIV5: begin
                dec_fact = FACT_5;
                dec_high = HIGH_5;
            end
            SEL_DIV6: begin
                dec_fact = FACT_6;
                dec_high = FACT_6 >> 1;
            end
            SEL_DIV8: begin
                dec_fact = FACT_8;
                dec_high = FACT_8 >> 1;
            end
            SEL_DIV9: begin
                dec_fact = FACT_9;
                dec_high = HIGH_9;
            end
            SEL_DIV10: begin
                dec_fact = FACT_10;
                dec_high = FACT_10 >> 1;
            end
        endcase
    end

    // Advisory flags of the decoded factor
    always_comb begin
        dec_odd  = (dec_fact == FACT_5) || (dec_fact == FACT_9);
        dec_fast = (int'(dec_fact) * CPU_MAX_MHZ < VCO_MHZ);
    end

    // ------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------
    logic [FACT_W-1:0] count;
    logic [FACT_W-1:0] fact_cur;
    logic [FACT_W-1:0] high_cur;
    logic [FACT_W-1:0] next_count;
    logic [FACT_W-1:0] next_fact;
    logic [FACT_W-1:0] next_high;
    logic              wrap;

    // End of the current output period
    assign wrap = (count == fact_cur - CNT_STEP);

    // Next position within the period
    always_comb begin
        if (wrap) begin
            next_count = CNT_ZERO;
        end else begin
            next_count = count + CNT_STEP;
        end
    end

    // Factor and high time for the next cycle
    always_comb begin
        if (wrap) begin
            next_fact = dec_fact;
            next_high = dec_high;
        end else begin
            next_fact = fact_cur;
            next_high = high_cur;
        end
    end

    // Count input cycles within one output period
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= CNT_ZERO;
        end else begin
            count <= next_count;
        end
    end

    // Factor in force, changed only at a period boundary
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fact_cur <= FACT_2;
        end else begin
            fact_cur <= next_fact;
        end
    end

    // High time in force, changed with the factor
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            high_cur <= RST_HIGH;
        end else begin
            high_cur <= next_high;
        end
    end

    // ------------------------------------------------------------
    // Divided clock output
    // ------------------------------------------------------------
    logic              next_pll_clk;

    // High for the first high_cur cycles of each period
    always_comb begin
        if (wrap) begin
            next_pll_clk = 1'b1;
        end else begin
            next_pll_clk = (next_count < high_cur);
        end
    end

    // Divided clock, no runt pulse at a factor change
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pll_clk <= 1'b1;
        end else begin
            pll_clk <= next_pll_clk;
        end
    end

    // ------------------------------------------------------------
    // Factor reporting
    // ------------------------------------------------------------

    // Factor of the period now running
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_factor <= FACT_2;
        end else begin
            div_factor <= next_fact;
        end
    end

    // Rate numerator, a fixed multiple of the input
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ratio_num <= 8'h00;
        end else begin
            ratio_num <= RATIO;
        end
    end

    // ------------------------------------------------------------
    // Advisory warnings
    // ------------------------------------------------------------
    logic              next_odd;
    logic              next_fast;

    // Warnings for the next cycle, taken with the factor
    always_comb begin
        if (wrap) begin
            next_odd  = dec_odd;
            next_fast = dec_fast;
        end else begin
            next_odd  = odd_factor;
            next_fast = over_limit;
        end
    end

    // Set while a factor software should avoid runs
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            odd_factor <= 1'b0;
        end else begin
            odd_factor <= next_odd;
        end
    end

    // Set from the first period boundary after reset while the output exceeds the processor limit
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            over_limit <= 1'b0;
        end else begin
            over_limit <= next_fast;
        end
    end

endmodule : pod_divider

// ### tb/pod_divider_props.sv
`timescale 1ns/100ps
module pod_divider_props
    import pod_pkg::*;
#(
    parameter int VCO_MHZ = VCO_MHZ_DEF
) (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              rst_b,
    // Watched ports
    input wire logic [2:0]        div_sel,
    input wire logic              pll_clk,
    input wire logic [FACT_W-1:0] div_factor,
    input wire logic [7:0]        ratio_num,
    input wire logic              odd_factor,
    input wire logic              over_limit
);
    localparam logic [4:0] DEC [8] = '{5'h02, 5'h10, 5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0A};
    logic       prev;
    logic       armed;
    logic [4:0] cnt;
    logic [4:0] hcnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // High time per factor
    function automatic logic [4:0] hi_of(input logic [4:0] k);
        return (k == 5'h05) ? 5'h02 : (k == 5'h09) ? 5'h04 : k >> 1;
    endfunction : hi_of
    // Cycles since last rise and high cycles in period
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev  <= 1'b1;
            armed <= 1'b0;
            cnt   <= 5'h00;
            hcnt  <= 5'h00;
        end else begin
            prev  <= pll_clk;
            armed <= armed | (pll_clk & ~prev);
            cnt   <= (pll_clk & ~prev) ? 5'h01 : cnt + 5'h01;
            hcnt  <= pll_clk ? (prev ? hcnt + 5'h01 : 5'h01) : hcnt;
        end
    end
    // Rise and fall of the divided clock
    sequence rise_s;
        pll_clk && !prev;
    endsequence : rise_s
    sequence fall_s;
        !pll_clk && prev;
    endsequence : fall_s
    period_len_a: assert property (armed ##0 rise_s |-> cnt == $past(div_factor))
        else $error("period length wrong");
    ratio_const_a: assert property ($past(rst_b) |-> ratio_num == 8'h0F)
        else $error("ratio not fifteen");
    sel_decode_a: assert property (rise_s |-> div_factor == DEC[$past(div_sel)])
        else $error("factor decode wrong");
    duty_high_a: assert property (fall_s |-> hcnt == hi_of(div_factor))
        else $error("high time wrong");
    status_flags_a: assert property (armed |-> odd_factor == (div_factor inside {5'h05, 5'h09})
        && over_limit == (int'(div_factor) * 40 < VCO_MHZ)) else $error("status flag wrong");
endmodule : pod_divider_props
bind pod_divider pod_divider_props #(.VCO_MHZ(VCO_MHZ)) pod_divider_props_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .div_sel(div_sel), .pll_clk(pll_clk),
    .div_factor(div_factor), .ratio_num(ratio_num), .odd_factor(odd_factor),
    .over_limit(over_limit));

// ### tb/pod_divider_bench.sv
`timescale 1ns/100ps
module pod_divider_bench import pod_pkg::*;;
    localparam logic [2:0] CS [8] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1};
    localparam logic [4:0] KS [8] = '{5'h02, 5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h10};
    localparam logic [4:0] HS [8] = '{5'h01, 5'h02, 5'h02, 5'h03, 5'h04, 5'h04, 5'h05, 5'h08};
    logic       sys_clk = 1'b0, rst_b = 1'b0, pll_clk, odd_factor, over_limit;
    logic [2:0] div_sel = 3'h0;
    logic [4:0] div_factor;
    logic [7:0] ratio_num;
    int         err_total = 0, samples_checked = 0, cyc = 0;
    pod_divider pod_divider_inst (.sys_clk(sys_clk), .rst_b(rst_b), .div_sel(div_sel),
        .pll_clk(pll_clk), .div_factor(div_factor), .ratio_num(ratio_num),
        .odd_factor(odd_factor), .over_limit(over_limit));
    // Clock and hang guard
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    // Wait for a rising edge of the divided clock
    task automatic rise();
        logic p;
        @(negedge sys_clk);
        do begin p = pll_clk; @(negedge sys_clk); end while (!(pll_clk === 1'b1 && p === 1'b0));
    endtask : rise
    // Measure one period starting at a rise
    task automatic meas(input logic [4:0] k, input logic [4:0] h);
        int n = 0, m = 0;
        logic p;
        do begin n++; m += int'(pll_clk); p = pll_clk; @(negedge sys_clk); end
        while (!(pll_clk === 1'b1 && p === 1'b0));
        chk(8'(n), 8'(k));
        chk(8'(m), 8'(h));
        chk(8'(div_factor), 8'(k));
        chk(8'(odd_factor), 8'(k == 5'h05 || k == 5'h09));
        chk(8'(over_limit), 8'(int'(k) * 40 < VCO_MHZ_DEF));
    endtask : meas
    task automatic t_reset();
        chk(8'(pll_clk), 8'h01);
        chk(8'(div_factor), 8'h02);
        chk(ratio_num, 8'h00);
        @(posedge sys_clk) rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) chk(ratio_num, 8'h0F);
        $display("test reset done");
    endtask : t_reset
    task automatic t_table();
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk) div_sel <= CS[i];
            rise();
            rise();
            meas(KS[i], HS[i]);
        end
        $display("test table done");
    endtask : t_table
    // Select change in mid-period must not take
    task automatic t_mid();
        @(posedge sys_clk) div_sel <= 3'h2;
        rise();
        rise();
        fork
            meas(5'h04, 5'h02);
            begin
                @(posedge sys_clk) div_sel <= 3'h1;
                @(posedge sys_clk) div_sel <= 3'h2;
            end
        join
        $display("test mid change done");
    endtask : t_mid
    initial begin
        repeat (20) @(posedge sys_clk);
        t_reset();
        t_table();
        t_mid();
        report_and_stop();
    end
endmodule : pod_divider_bench
